// *** include/dsbdp_defs.svh ***
`ifndef DSBDP_DEFS_SVH
`define DSBDP_DEFS_SVH
// Burst length in words
`define DSBDP_BURST_LEN 2
// Read latency in mclk cycles spent in DSBDP_RLAT before the DSBDP_RD beats
`define DSBDP_RD_LAT 2
// Direction encoding on read_write
`define DSBDP_DIR_READ 1'b1
`define DSBDP_DIR_WRITE 1'b0
// Beat phase encoding
`define DSBDP_BEAT_TRUE 1'b0
`define DSBDP_BEAT_COMP 1'b1
`endif

// *** include/dsbdp_pkg.sv ***
package dsbdp_pkg;
	typedef enum logic [3:0] {
		DSBDP_IDLE = 4'b0001,
		DSBDP_WR   = 4'b0010,
		DSBDP_RLAT = 4'b0100,
		DSBDP_RD   = 4'b1000
	} dsbdp_state_e;
endpackage

// *** logic/dsbdp_port.sv ***
`timescale 1ns/1ps
`include "dsbdp_defs.svh"
module dsbdp_port
	import dsbdp_pkg::*;
#(
	parameter int LANE_W = 9,
	parameter int LANES  = 2,
	parameter int ADDR_W = 8
) (
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire logic                      clk_en,
	input  wire logic                      beat_phase,
	input  wire logic                      cycle_define_n,
	input  wire logic                      read_write,
	input  wire logic [ADDR_W-1:0]         addr,
	input  wire logic [LANES-1:0]          lane_write_select_n,
	input  wire logic [LANE_W*LANES-1:0]   dq_in,
	output logic      [LANE_W*LANES-1:0]   dq_out,
	output logic                           dq_oe,
	output logic                           output_valid,
	output logic                           echo_clock
);
	localparam int DW = LANE_W * LANES;

	// Pin synchronisers, two stages
	logic                cdn_s1_r;
	logic                cdn_s2_r;
	logic                rw_s1_r;
	logic                rw_s2_r;
	logic                ph_s1_r;
	logic                ph_s2_r;
	logic [ADDR_W-1:0]   a_s1_r;
	logic [ADDR_W-1:0]   a_s2_r;
	logic [LANES-1:0]    bw_s1_r;
	logic [LANES-1:0]    bw_s2_r;
	logic [DW-1:0]       d_s1_r;
	logic [DW-1:0]       d_s2_r;

	// Only the second stage feeds logic
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cdn_s1_r <= 1'b1;
			cdn_s2_r <= 1'b1;
			rw_s1_r  <= 1'b0;
			rw_s2_r  <= 1'b0;
			ph_s1_r  <= 1'b0;
			ph_s2_r  <= 1'b0;
			a_s1_r   <= '0;
			a_s2_r   <= '0;
			bw_s1_r  <= '1;
			bw_s2_r  <= '1;
			d_s1_r   <= '0;
			d_s2_r   <= '0;
		end else if (clk_en) begin
			cdn_s1_r <= cycle_define_n;
			cdn_s2_r <= cdn_s1_r;
			rw_s1_r  <= read_write;
			rw_s2_r  <= rw_s1_r;
			ph_s1_r  <= beat_phase;
			ph_s2_r  <= ph_s1_r;
			a_s1_r   <= addr;
			a_s2_r   <= a_s1_r;
			bw_s1_r  <= lane_write_select_n;
			bw_s2_r  <= bw_s1_r;
			d_s1_r   <= dq_in;
			d_s2_r   <= d_s1_r;
		end
	end

	logic [DW-1:0] mem [0:(2**ADDR_W)*`DSBDP_BURST_LEN-1];

	dsbdp_state_e      state_r;
	dsbdp_state_e      state_nxt;
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;
	logic              beat_r;
	logic              beat_nxt;
	logic [1:0]        lat_r;
	logic [1:0]        lat_nxt;
	logic              define_edge;
	logic              wr_en;
	logic [ADDR_W:0]   mem_idx;
	logic [LANES-1:0]  lane_we;

	assign define_edge = !cdn_s2_r && (ph_s2_r == `DSBDP_BEAT_TRUE);

	always_comb begin
		state_nxt = state_r;
		addr_nxt  = addr_r;
		beat_nxt  = beat_r;
		lat_nxt   = lat_r;
		wr_en     = 1'b0;
		case (state_r)
			DSBDP_IDLE: begin
				if (define_edge) begin
					addr_nxt = a_s2_r;
					beat_nxt = `DSBDP_BEAT_TRUE;
					if (rw_s2_r == `DSBDP_DIR_READ) begin
						state_nxt = DSBDP_RLAT;
						lat_nxt   = 2'(`DSBDP_RD_LAT - 1);
					end else begin
						state_nxt = DSBDP_WR;
					end
				end
			end
			DSBDP_WR: begin
				wr_en    = 1'b1;
				beat_nxt = ~beat_r;
				if (beat_r == `DSBDP_BEAT_COMP) begin
					state_nxt = DSBDP_IDLE;
				end
			end
			DSBDP_RLAT: begin
				// Read latency countdown
				if (lat_r == 2'd0) begin
					state_nxt = DSBDP_RD;
				end else begin
					lat_nxt = lat_r - 2'd1;
				end
			end
			DSBDP_RD: begin
				beat_nxt = ~beat_r;
				if (beat_r == `DSBDP_BEAT_COMP) begin
					state_nxt = DSBDP_IDLE;
				end
			end
			default: begin
				state_nxt = DSBDP_IDLE;
			end
		endcase
	end

	// word index from address and beat
	assign mem_idx = {addr_r, beat_r};

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= DSBDP_IDLE;
			addr_r  <= '0;
			beat_r  <= 1'b0;
			lat_r   <= '0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			addr_r  <= addr_nxt;
			beat_r  <= beat_nxt;
			lat_r   <= lat_nxt;
		end
	end

	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			lane_we[i] = wr_en && !bw_s2_r[i];
		end
	end

	always_ff @(posedge mclk) begin
		if (clk_en) begin
			for (int i = 0; i < LANES; i++) begin
				if (lane_we[i]) begin
					mem[mem_idx][i*LANE_W +: LANE_W] <=
						d_s2_r[i*LANE_W +: LANE_W];
				end
			end
		end
	end

	logic [DW-1:0] q_nxt;
	logic [DW-1:0] q_r;
	logic          oe_nxt;
	logic          oe_r;
	logic          echo_nxt;
	logic          echo_r;

	always_comb begin
		oe_nxt   = (state_r == DSBDP_RD);
		echo_nxt = ~echo_r;
		q_nxt    = '0;
		if (oe_nxt) begin
			q_nxt = mem[mem_idx];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q_r    <= '0;
			oe_r   <= 1'b0;
			echo_r <= 1'b0;
		end else if (clk_en) begin
			q_r    <= q_nxt;
			oe_r   <= oe_nxt;
			echo_r <= echo_nxt;
		end
	end

	assign dq_out       = q_r;
	assign dq_oe        = oe_r;
	assign output_valid = oe_r;
	assign echo_clock   = echo_r;
endmodule

// *** verification/dsbdp_chk.sv ***
`timescale 1ns/1ps
module dsbdp_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic beat_phase,
	input wire logic cycle_define_n,
	input wire logic read_write,
	input wire logic dq_oe,
	input wire logic output_valid,
	input wire logic echo_clock
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_oe; dq_oe == output_valid; endproperty
	a_oe: assert property (p_oe) else $error("oe");
	property p_two; $rose(dq_oe) |=> dq_oe ##1 !dq_oe; endproperty
	a_two: assert property (p_two) else $error("len");
	property p_rd; !cycle_define_n && read_write && !beat_phase
		|-> ##[3:9] $rose(output_valid); endproperty
	a_rd: assert property (p_rd) else $error("rd");
	property p_wr; !cycle_define_n && !read_write |-> !dq_oe[*6];
		endproperty
	a_wr: assert property (p_wr) else $error("wr");
	property p_ph; !cycle_define_n && beat_phase |-> !dq_oe[*8]; endproperty
	a_ph: assert property (p_ph) else $error("ph");
	property p_lat; !cycle_define_n |-> !dq_oe[*3]; endproperty
	a_lat: assert property (p_lat) else $error("lat");
	property p_off; cycle_define_n[*8] |-> ##2 !dq_oe; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_eck; !$past(rst) |-> echo_clock != $past(echo_clock);
		endproperty
	a_eck: assert property (p_eck) else $error("eck");
endmodule

// *** verification/dsbdp_ctl.sv ***
`timescale 1ns/1ps
module dsbdp_ctl (
	input  wire logic   mclk,
	output logic        beat_phase = 1'h0,
	output logic        cycle_define_n = 1'h1,
	output logic        read_write = 1'h0,
	output logic [7:0]  addr = 8'h0,
	output logic [1:0]  lane_write_select_n = 2'h3,
	output logic [17:0] dq_in = 18'h0
);
	task automatic cmd(logic rw, ph, logic [7:0] a, logic [35:0] d,
			logic [3:0] s);
		cycle_define_n <= 1'h0;
		read_write <= rw;
		addr <= a;
		beat_phase <= ph;
		dq_in <= ~dq_in;
		@(posedge mclk);
		cycle_define_n <= 1'h1;
		read_write <= ~rw;
		addr <= ~a;
		beat_phase <= 1'h0;
		dq_in <= d[17:0];
		lane_write_select_n <= s[1:0];
		@(posedge mclk);
		beat_phase <= 1'h1;
		dq_in <= d[35:18];
		lane_write_select_n <= s[3:2];
		@(posedge mclk);
		dq_in <= ~dq_in;
		@(posedge mclk);
	endtask
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic        mclk, rst, clk_en = 1'h1, beat_phase, cycle_define_n;
	logic        read_write, dq_oe, output_valid, echo_clock;
	logic [1:0]  lane_write_select_n;
	logic [7:0]  addr;
	logic [17:0] dq_in, dq_out, mem [int];
	logic [31:0] seed = 32'h56a1;
	int          n_errors, checks, cyc;
	dsbdp_port dsbdp_port_i (.*);
	dsbdp_ctl dsbdp_ctl_i (.*);
	initial begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 4000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic chk(string nm, logic [17:0] e, g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	function automatic logic [31:0] xorshift(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic wr(logic [7:0] a, logic [3:0] s);
		seed = xorshift(seed);
		dsbdp_ctl_i.cmd(1'h0, 1'h0, a, {seed[3:0], seed}, s);
		for (int i = 0; i < 4; i++) begin
			if (!s[i]) begin
				mem[a*2+i/2][i%2*9+:9] = {seed[3:0], seed} >> (i*9);
			end
		end
	endtask
	task automatic rd(logic [7:0] a);
		dsbdp_ctl_i.cmd(1'h1, 1'h0, a, 36'h0, 4'hf);
		for (int n = 0; n < 12 && output_valid !== 1'h1; n++) begin
			@(negedge mclk);
		end
		chk("valid", 18'h1, {17'h0, output_valid});
		chk("word0", mem[a*2], dq_out);
		@(negedge mclk);
		chk("word1", mem[a*2+1], dq_out);
		@(negedge mclk);
		chk("oe", 18'h0, {17'h0, dq_oe});
		@(posedge mclk);
	endtask
	initial begin
		rst = 1'h1;
		repeat (20) @(posedge mclk);
		rst <= 1'h0;
		@(posedge mclk);
		dsbdp_ctl_i.cmd(1'h1, 1'h1, 8'h0, 36'h0, 4'hf);
		repeat (8) begin
			@(negedge mclk);
			chk("ph", 18'h0, {17'h0, dq_oe});
		end
		@(posedge mclk);
		for (int k = 0; k < 6; k++) begin
			wr(8'(k * 51), 4'h0);
			wr(8'(k * 51), seed[7:4]);
			rd(8'(k * 51));
		end
		for (int k = 0; k < 6; k++) begin
			rd(8'(k * 51));
		end
		final_report();
	end
endmodule
bind dsbdp_port dsbdp_chk dsbdp_chk_i (.*);
